// >>> verilog/slave_ctrl_regs.svh
`ifndef SLAVE_CTRL_REGS_SVH
`define SLAVE_CTRL_REGS_SVH

`define OFS_TASK_ACQUIRE   12'h024
`define OFS_TASK_RELEASE   12'h028
`define OFS_EV_DONE        12'h104
`define OFS_EV_RXFULL      12'h110
`define OFS_EV_GRANTED     12'h128
`define OFS_SHORTCUT       12'h200
`define OFS_INT_ENABLE     12'h304
`define OFS_INT_DISABLE    12'h308
`define OFS_SEM_OWNER      12'h400
`define OFS_ERR_STATUS     12'h440
`define OFS_PERIPH_EN      12'h500
`define OFS_RX_MAX         12'h538
`define OFS_TX_MAX         12'h548
`define OFS_TX_FILL        12'h5C0

`define BIT_EV_DONE        0
`define BIT_EV_RXFULL      1
`define BIT_EV_GRANTED     2
`define BIT_ERR_UNDERRUN   0
`define BIT_ERR_OVERFLOW   1

`define PERIPH_EN_ON       4'h2
`define PERIPH_EN_OFF      4'h0
`define SEM_OWNER_RESET    32'h00000001
`define TX_FILL_RESET      8'hFF

`endif

// >>> verilog/slave_ctrl_pkg.sv
package slave_ctrl_pkg;
  typedef enum logic [1:0] {
    SEM_FREE,
    SEM_CPU,
    SEM_SERIAL,
    SEM_WAITING
  } sem_state_type;
endpackage

// >>> verilog/link_if.sv
interface link_if;
  logic       enable;
  logic       frame_start;
  logic       frame_end;
  logic       byte_done;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;

  modport sampler (input enable, input tx_byte, output frame_start, output frame_end,
                   output byte_done, output rx_byte);
  modport core (output enable, output tx_byte, input frame_start, input frame_end,
                input byte_done, input rx_byte);
endinterface

// >>> verilog/serial_sampler.sv
module serial_sampler (
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  input  wire logic sck_i,
  input  wire logic csn_i,
  input  wire logic mosi_i,
  output logic      miso_o,
  output logic      miso_oe_n_o,
  link_if.sampler   link
);
  logic [2:0] s1_r, s2_r, s1_nxt, s2_nxt;
  logic       sck_d_r, csn_d_r, sck_d_nxt, csn_d_nxt;
  logic       in_frame_r, in_frame_nxt;
  logic       oe_n_r, oe_n_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt, tx_sh_r, tx_sh_nxt;
  logic       start_r, end_r, done_r, start_nxt, end_nxt, done_nxt;
  logic       rise, fall;

  // s1 feeds s2 only; edges come from s2 against its delayed copy
  always_comb begin
    s1_nxt       = {mosi_i, csn_i, sck_i};
    s2_nxt       = s1_r;
    sck_d_nxt    = s2_r[0];
    csn_d_nxt    = s2_r[1];
    rise         = s2_r[0] & ~sck_d_r;
    fall         = ~s2_r[0] & sck_d_r;
    in_frame_nxt = in_frame_r;
    bit_cnt_nxt  = bit_cnt_r;
    rx_sh_nxt    = rx_sh_r;
    tx_sh_nxt    = tx_sh_r;
    start_nxt    = 1'b0;
    end_nxt      = 1'b0;
    done_nxt     = 1'b0;
    if (csn_d_r && !s2_r[1] && link.enable) begin
      in_frame_nxt = 1'b1;
      start_nxt    = 1'b1;
      bit_cnt_nxt  = 3'h0;
      tx_sh_nxt    = link.tx_byte;
    end else if (in_frame_r && s2_r[1]) begin
      in_frame_nxt = 1'b0;
      end_nxt      = 1'b1;
    end else if (in_frame_r && rise) begin
      rx_sh_nxt   = {rx_sh_r[6:0], s2_r[2]};
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      if (bit_cnt_r == 3'h7) begin
        done_nxt  = 1'b1;
        tx_sh_nxt = link.tx_byte;
      end
    end else if (in_frame_r && fall && bit_cnt_r != 3'h0) begin
      tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
    end
    oe_n_nxt = ~in_frame_nxt;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // sck rests low in mode 0; a high reset value would fake a falling edge
      s1_r       <= 3'h2;
      s2_r       <= 3'h2;
      sck_d_r    <= 1'b0;
      oe_n_r     <= 1'b1;
      csn_d_r    <= 1'b1;
      in_frame_r <= 1'b0;
      bit_cnt_r  <= 3'h0;
      rx_sh_r    <= 8'h00;
      tx_sh_r    <= 8'h00;
      start_r    <= 1'b0;
      end_r      <= 1'b0;
      done_r     <= 1'b0;
    end else begin
      s1_r       <= s1_nxt;
      s2_r       <= s2_nxt;
      sck_d_r    <= sck_d_nxt;
      csn_d_r    <= csn_d_nxt;
      in_frame_r <= in_frame_nxt;
      oe_n_r     <= oe_n_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      rx_sh_r    <= rx_sh_nxt;
      tx_sh_r    <= tx_sh_nxt;
      start_r    <= start_nxt;
      end_r      <= end_nxt;
      done_r     <= done_nxt;
    end
  end

  assign link.frame_start = start_r;
  assign link.frame_end   = end_r;
  assign link.byte_done   = done_r;
  assign link.rx_byte     = rx_sh_r;
  assign miso_o           = tx_sh_r[7];
  assign miso_oe_n_o      = oe_n_r;

  disabled_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !link.enable && !in_frame_r |=> !start_r)
    else $error("frame started while disabled");
endmodule

// >>> verilog/sem_arbiter.sv
module sem_arbiter
  import slave_ctrl_pkg::*;
(
  input  wire logic          ref_clk_i,
  input  wire logic          resetn_i,
  input  wire logic          acquire_i,
  input  wire logic          release_i,
  input  wire logic          shortcut_i,
  input  wire logic          frame_start_i,
  input  wire logic          frame_end_i,
  output sem_state_type      state_o,
  output logic               held_o,
  output logic               done_o,
  output logic               granted_o
);
  sem_state_type state_r, state_nxt;

  // acquire and release never both leave the owner in two places at once
  always_comb begin
    state_nxt = state_r;
    done_o    = 1'b0;
    case (state_r)
      SEM_FREE: begin
        if (acquire_i) begin
          state_nxt = SEM_CPU;
        end else if (frame_start_i) begin
          state_nxt = SEM_SERIAL;
        end
      end
      SEM_CPU: begin
        if (release_i) begin
          state_nxt = SEM_FREE;
        end
      end
      SEM_SERIAL: begin
        if (frame_end_i) begin
          done_o    = 1'b1;
          state_nxt = (acquire_i || shortcut_i) ? SEM_CPU : SEM_FREE;
        end else if (acquire_i) begin
          state_nxt = SEM_WAITING;
        end
      end
      SEM_WAITING: begin
        if (frame_end_i) begin
          done_o    = 1'b1;
          state_nxt = SEM_CPU;
        end
      end
      default: state_nxt = SEM_CPU;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= SEM_CPU;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign state_o   = state_r;
  assign held_o    = (state_r == SEM_SERIAL) || (state_r == SEM_WAITING);
  assign granted_o = (state_nxt == SEM_CPU) && (state_r != SEM_CPU);

  release_free_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_r == SEM_CPU && release_i |=> state_r == SEM_FREE)
    else $error("release did not free semaphore");
  waiting_origin_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_r == SEM_WAITING |-> $past(state_r) inside {SEM_SERIAL, SEM_WAITING})
    else $error("handover wait without serial owner");
  done_event_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    held_o && frame_end_i |-> done_o ##1 state_r != SEM_SERIAL)
    else $error("held frame end without done");
endmodule

// >>> verilog/spi_slave_semaphore_status.sv
// Implementation choice: the strobed register port.
`include "slave_ctrl_regs.svh"

module spi_slave_semaphore_status
  import slave_ctrl_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             irq_o,
  input  wire logic        sck_i,
  input  wire logic        csn_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic             miso_oe_n_o
);
  import slave_ctrl_pkg::*;

  link_if link ();

  logic [2:0]       int_en_r, int_en_nxt;
  logic [2:0]       ev_r, ev_nxt;
  logic [1:0]       err_r, err_nxt;
  logic [3:0]       en_r, en_nxt;
  logic             short_r, short_nxt;
  logic [CNT_W-1:0] rx_max_r, rx_max_nxt, tx_max_r, tx_max_nxt;
  logic [CNT_W-1:0] rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
  logic [7:0]       fill_r, fill_nxt;
  logic [31:0]      rdata_r, rdata_nxt;
  logic             irq_r, irq_nxt;
  logic             enabled, acquire, release_t, held, done_ev, granted_ev;
  logic [2:0]       ev_set;
  logic [1:0]       err_set;
  sem_state_type    sem_state;

  function automatic logic wr_hit(input logic [11:0] ofs);
    wr_hit = wr_i && (addr_i == ofs);
  endfunction

  // sticky bit: a set in the same cycle as a written one wins
  function automatic logic w1c(input logic old, input logic set, input logic clr);
    w1c = set | (old & ~clr);
  endfunction

  function automatic logic [31:0] owner_code(input sem_state_type s);
    case (s)
      SEM_FREE:    owner_code = 32'h00000000;
      SEM_CPU:     owner_code = 32'h00000001;
      SEM_SERIAL:  owner_code = 32'h00000002;
      SEM_WAITING: owner_code = 32'h00000003;
      default:     owner_code = 32'h00000000;
    endcase
  endfunction

  assign enabled   = (en_r == `PERIPH_EN_ON);
  assign acquire   = wr_hit(`OFS_TASK_ACQUIRE) && wdata_i[0];
  assign release_t = wr_hit(`OFS_TASK_RELEASE) && wdata_i[0];

  assign link.enable  = enabled;
  // no transmit buffer here: every clocked-out byte is the fill character
  assign link.tx_byte = fill_r;

  serial_sampler u_sampler (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .sck_i       (sck_i),
    .csn_i       (csn_i),
    .mosi_i      (mosi_i),
    .miso_o      (miso_o),
    .miso_oe_n_o (miso_oe_n_o),
    .link        (link.sampler)
  );

  sem_arbiter u_arbiter (
    .ref_clk_i     (ref_clk_i),
    .resetn_i      (resetn_i),
    .acquire_i     (acquire),
    .release_i     (release_t),
    .shortcut_i    (short_r),
    .frame_start_i (link.frame_start),
    .frame_end_i   (link.frame_end),
    .state_o       (sem_state),
    .held_o        (held),
    .done_o        (done_ev),
    .granted_o     (granted_ev)
  );

  // byte accounting only while the serial side holds the buffers
  always_comb begin
    rx_cnt_nxt = rx_cnt_r;
    tx_cnt_nxt = tx_cnt_r;
    ev_set     = 3'h0;
    err_set    = 2'h0;
    if (link.frame_start) begin
      rx_cnt_nxt = '0;
      tx_cnt_nxt = '0;
    end else if (link.byte_done && held) begin
      if (rx_cnt_r < rx_max_r) begin
        rx_cnt_nxt = rx_cnt_r + 1'b1;
        if (rx_cnt_r + 1'b1 == rx_max_r) begin
          ev_set[`BIT_EV_RXFULL] = 1'b1;
        end
      end else begin
        err_set[`BIT_ERR_OVERFLOW] = 1'b1;
      end
      if (tx_cnt_r < tx_max_r) begin
        tx_cnt_nxt = tx_cnt_r + 1'b1;
      end else begin
        err_set[`BIT_ERR_UNDERRUN] = 1'b1;
      end
    end
    ev_set[`BIT_EV_DONE]    = done_ev;
    ev_set[`BIT_EV_GRANTED] = granted_ev;
  end

  always_comb begin
    int_en_nxt = int_en_r;
    short_nxt  = short_r;
    en_nxt     = en_r;
    rx_max_nxt = rx_max_r;
    tx_max_nxt = tx_max_r;
    fill_nxt   = fill_r;
    if (wr_hit(`OFS_INT_ENABLE)) begin
      int_en_nxt = int_en_r | wdata_i[2:0];
    end
    if (wr_hit(`OFS_INT_DISABLE)) begin
      int_en_nxt = int_en_r & ~wdata_i[2:0];
    end
    if (wr_hit(`OFS_SHORTCUT)) begin
      short_nxt = wdata_i[0];
    end
    if (wr_hit(`OFS_PERIPH_EN)) begin
      en_nxt = wdata_i[3:0];
    end
    if (wr_hit(`OFS_RX_MAX)) begin
      rx_max_nxt = wdata_i[CNT_W-1:0];
    end
    if (wr_hit(`OFS_TX_MAX)) begin
      tx_max_nxt = wdata_i[CNT_W-1:0];
    end
    if (wr_hit(`OFS_TX_FILL)) begin
      fill_nxt = wdata_i[7:0];
    end
    ev_nxt[`BIT_EV_DONE]    = w1c(ev_r[`BIT_EV_DONE], ev_set[`BIT_EV_DONE],
                                  wr_hit(`OFS_EV_DONE) && wdata_i[0]);
    ev_nxt[`BIT_EV_RXFULL]  = w1c(ev_r[`BIT_EV_RXFULL], ev_set[`BIT_EV_RXFULL],
                                  wr_hit(`OFS_EV_RXFULL) && wdata_i[0]);
    ev_nxt[`BIT_EV_GRANTED] = w1c(ev_r[`BIT_EV_GRANTED], ev_set[`BIT_EV_GRANTED],
                                  wr_hit(`OFS_EV_GRANTED) && wdata_i[0]);
    for (int i = 0; i < 2; i++) begin
      err_nxt[i] = w1c(err_r[i], err_set[i],
                       wr_hit(`OFS_ERR_STATUS) && wdata_i[i]);
    end
    irq_nxt = |(ev_nxt & int_en_nxt);
  end

  // unmapped addresses read as zero; read data valid the cycle after rd_i
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (rd_i) begin
      case (addr_i)
        `OFS_EV_DONE:     rdata_nxt = {31'h0, ev_r[`BIT_EV_DONE]};
        `OFS_EV_RXFULL:   rdata_nxt = {31'h0, ev_r[`BIT_EV_RXFULL]};
        `OFS_EV_GRANTED:  rdata_nxt = {31'h0, ev_r[`BIT_EV_GRANTED]};
        `OFS_SHORTCUT:    rdata_nxt = {31'h0, short_r};
        `OFS_INT_ENABLE:  rdata_nxt = {29'h0, int_en_r};
        `OFS_INT_DISABLE: rdata_nxt = {29'h0, int_en_r};
        `OFS_SEM_OWNER:   rdata_nxt = owner_code(sem_state);
        `OFS_ERR_STATUS:  rdata_nxt = {30'h0, err_r};
        `OFS_PERIPH_EN:   rdata_nxt = {28'h0, en_r};
        `OFS_RX_MAX:      rdata_nxt = {{(32-CNT_W){1'b0}}, rx_max_r};
        `OFS_TX_MAX:      rdata_nxt = {{(32-CNT_W){1'b0}}, tx_max_r};
        `OFS_TX_FILL:     rdata_nxt = {24'h0, fill_r};
        default:          rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_en_r <= 3'h0;
      ev_r     <= 3'h0;
      err_r    <= 2'h0;
      en_r     <= `PERIPH_EN_OFF;
      short_r  <= 1'b0;
      rx_max_r <= '0;
      tx_max_r <= '0;
      rx_cnt_r <= '0;
      tx_cnt_r <= '0;
      fill_r   <= `TX_FILL_RESET;
      rdata_r  <= 32'h00000000;
      irq_r    <= 1'b0;
    end else begin
      int_en_r <= int_en_nxt;
      ev_r     <= ev_nxt;
      err_r    <= err_nxt;
      en_r     <= en_nxt;
      short_r  <= short_nxt;
      rx_max_r <= rx_max_nxt;
      tx_max_r <= tx_max_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      fill_r   <= fill_nxt;
      rdata_r  <= rdata_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign irq_o   = irq_r;

  int_disable_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_hit(`OFS_INT_DISABLE) && wdata_i[0] && !wr_hit(`OFS_INT_ENABLE) |=> !int_en_r[0])
    else $error("interrupt enable not cleared");
  owner_read_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_i && addr_i == `OFS_SEM_OWNER |=> rdata_o == owner_code($past(sem_state)))
    else $error("owner field mismatch");
  reset_owner_a: assert property (@(posedge ref_clk_i)
    $rose(resetn_i) |-> sem_state == SEM_CPU)
    else $error("semaphore not with CPU after reset");
  err_clear_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_hit(`OFS_ERR_STATUS) && wdata_i[1] && !err_set[1] |=> !err_r[1])
    else $error("overflow flag not cleared");
  err_sticky_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    err_r[0] && !(wr_hit(`OFS_ERR_STATUS) && wdata_i[0]) |=> err_r[0])
    else $error("under-run flag lost");
  overflow_set_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    link.byte_done && held && rx_cnt_r >= rx_max_r |=> err_r[1] && $stable(rx_cnt_r))
    else $error("overflow not flagged or count moved");
  underrun_set_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    link.byte_done && held && tx_cnt_r >= tx_max_r |=> err_r[0] && $stable(tx_cnt_r))
    else $error("under-run not flagged or count moved");
  rx_full_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    link.byte_done && held && rx_cnt_r + 1'b1 == rx_max_r |=> ev_r[`BIT_EV_RXFULL])
    else $error("rx full event missing");
  irq_level_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ##1 irq_o == |(ev_r & int_en_r))
    else $error("irq level mismatch");

  // ownership moves only on request, release, frame start or frame end
  grant_free_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    sem_state == SEM_FREE && acquire |=> sem_state == SEM_CPU && ev_r[`BIT_EV_GRANTED])
    else $error("acquire on free semaphore not granted");
  serial_take_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    sem_state == SEM_FREE && link.frame_start && !acquire |=> sem_state == SEM_SERIAL)
    else $error("frame start did not hand owner to serial side");
  grant_after_wait_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    sem_state == SEM_WAITING && link.frame_end |=> sem_state == SEM_CPU
      && ev_r[`BIT_EV_GRANTED])
    else $error("pending handover not completed");
  done_flag_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    held && link.frame_end |=> ev_r[`BIT_EV_DONE])
    else $error("done event flag not set");
  shortcut_grant_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    sem_state == SEM_SERIAL && link.frame_end && short_r |=> sem_state == SEM_CPU)
    else $error("shortcut did not return owner to CPU");
  cpu_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    sem_state == SEM_CPU && !release_t |=> sem_state == SEM_CPU)
    else $error("CPU lost owner without release");
  serial_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    held && !link.frame_end |=> held)
    else $error("serial side lost owner before frame end");
  // a frame already running when disabled is let run to its end
  disabled_idle_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !enabled && !held && !link.frame_start |=> !held)
    else $error("disabled block took the semaphore");
  enable_decode_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_hit(`OFS_PERIPH_EN) |=> enabled == ($past(wdata_i[3:0]) == `PERIPH_EN_ON))
    else $error("enable field decode mismatch");
  int_keep_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_hit(`OFS_INT_DISABLE) |=> (int_en_r | $past(wdata_i[2:0])) ==
      ($past(int_en_r) | $past(wdata_i[2:0])))
    else $error("zero bits of disable write changed an enable");
  underrun_clear_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_hit(`OFS_ERR_STATUS) && wdata_i[0] && !err_set[0] |=> !err_r[0])
    else $error("under-run flag not cleared");
  overflow_sticky_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    err_r[1] && !(wr_hit(`OFS_ERR_STATUS) && wdata_i[1]) |=> err_r[1])
    else $error("overflow flag lost");
  rx_count_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    link.byte_done && held && rx_cnt_r < rx_max_r |=> rx_cnt_r == $past(rx_cnt_r) + 1'b1)
    else $error("received byte not counted");
  frame_count_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    link.frame_start |=> rx_cnt_r == '0 && tx_cnt_r == '0)
    else $error("byte counts not cleared at frame start");
endmodule

// >>> testbench/spi_master_model.sv
module spi_master_model (
  input  wire logic ref_clk_i,
  input  wire logic miso_i,
  output logic      sck_o,
  output logic      csn_o,
  output logic      mosi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] seen;

  // mode 0: clock idles low between frames
  initial begin
    sck_o  = 1'b0;
    csn_o  = 1'b1;
    mosi_o = 1'b0;
    seen   = 8'h00;
  end

  // select lead of 10 clocks covers the sync delay
  task automatic cs_low();
    @(posedge ref_clk_i);
    csn_o <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
  endtask

  // 80 ns bit period, msb first, miso taken on the rising edge
  task automatic xfer(input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++) begin
      for (int k = 7; k >= 0; k--) begin
        mosi_o <= b[k];
        repeat (10) @(posedge ref_clk_i);
        sck_o <= 1'b1;
        seen  <= {seen[6:0], miso_i};
        repeat (10) @(posedge ref_clk_i);
        sck_o <= 1'b0;
      end
    end
  endtask

  // released data line flips so a stale level is never trusted
  task automatic cs_high();
    @(posedge ref_clk_i);
    csn_o  <= 1'b1;
    mosi_o <= ~mosi_o;
    repeat (10) @(posedge ref_clk_i);
  endtask
endmodule

// >>> testbench/spi_slave_semaphore_status_tb.sv
module spi_slave_semaphore_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk;
  logic        resetn;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        irq;
  logic        sck;
  logic        csn;
  logic        mosi;
  logic        miso;
  logic        miso_oe_n;
  logic        miso_line;
  int          n_mismatch;
  int          comparisons;

  spi_slave_semaphore_status DUT (
    .ref_clk_i   (ref_clk),
    .resetn_i    (resetn),
    .addr_i      (addr),
    .wdata_i     (wdata),
    .wr_i        (wr),
    .rd_i        (rd),
    .rdata_o     (rdata),
    .irq_o       (irq),
    .sck_i       (sck),
    .csn_i       (csn),
    .mosi_i      (mosi),
    .miso_o      (miso),
    .miso_oe_n_o (miso_oe_n)
  );

  // an undriven data line shows the inverse of its last level
  assign miso_line = miso_oe_n ? ~miso : miso;

  spi_master_model m (
    .ref_clk_i (ref_clk),
    .miso_i    (miso_line),
    .sck_o     (sck),
    .csn_o     (csn),
    .mosi_o    (mosi)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp, input string nm);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    chk(nm, rdata, exp);
  endtask

  // interrupt output updates with the registers; the wait only adds margin
  task automatic chk_irq(input logic exp);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #50000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    addr   = 12'h000;
    wdata  = 32'h0;
    wr     = 1'b0;
    rd     = 1'b0;
    resetn = 1'b0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    rd_reg(12'h308, 32'h0, "int_disable");
    rd_reg(12'h400, 32'h1, "owner");
    rd_reg(12'h440, 32'h0, "errors");
    rd_reg(12'h500, 32'h0, "enable");
    rd_reg(12'h7FC, 32'h0, "unmapped");
    wr_reg(12'h400, 32'h0);
    rd_reg(12'h400, 32'h1, "owner ro");
    wr_reg(12'h304, 32'h7);
    rd_reg(12'h308, 32'h7, "int_disable");
    wr_reg(12'h308, 32'h2);
    rd_reg(12'h308, 32'h5, "int_disable");
    wr_reg(12'h308, 32'h0);
    rd_reg(12'h308, 32'h5, "int_disable");
    wr_reg(12'h308, 32'h5);
    rd_reg(12'h304, 32'h0, "int_enable");
    // frame while disabled must leave no trace
    wr_reg(12'h028, 32'h1);
    rd_reg(12'h400, 32'h0, "owner");
    m.cs_low();
    m.xfer(1, 8'h5A);
    m.cs_high();
    rd_reg(12'h400, 32'h0, "owner");
    rd_reg(12'h440, 32'h0, "errors");
    rd_reg(12'h104, 32'h0, "done ev");
    wr_reg(12'h500, 32'h2);
    rd_reg(12'h500, 32'h2, "enable");
    wr_reg(12'h538, 32'h2);
    wr_reg(12'h548, 32'h2);
    wr_reg(12'h5C0, 32'hA5);
    // one byte past both maxima
    m.cs_low();
    rd_reg(12'h400, 32'h2, "owner");
    chk("oe_n", {31'h0, miso_oe_n}, 32'h0);
    m.xfer(3, 8'h5A);
    chk("miso byte", {24'h0, m.seen}, 32'hA5);
    rd_reg(12'h110, 32'h1, "rxfull ev");
    rd_reg(12'h440, 32'h3, "errors");
    rd_reg(12'h104, 32'h0, "done ev");
    m.cs_high();
    rd_reg(12'h400, 32'h0, "owner");
    rd_reg(12'h104, 32'h1, "done ev");
    chk("oe_n", {31'h0, miso_oe_n}, 32'h1);
    chk_irq(1'b0);
    wr_reg(12'h304, 32'h1);
    chk_irq(1'b1);
    wr_reg(12'h308, 32'h1);
    chk_irq(1'b0);
    wr_reg(12'h304, 32'h1);
    wr_reg(12'h104, 32'h1);
    chk_irq(1'b0);
    rd_reg(12'h104, 32'h0, "done ev");
    wr_reg(12'h440, 32'h0);
    rd_reg(12'h440, 32'h3, "errors");
    wr_reg(12'h440, 32'h1);
    rd_reg(12'h440, 32'h2, "errors");
    wr_reg(12'h440, 32'h2);
    rd_reg(12'h440, 32'h0, "errors");
    // cpu asks while the serial side holds the buffers
    m.cs_low();
    rd_reg(12'h400, 32'h2, "owner");
    wr_reg(12'h024, 32'h1);
    rd_reg(12'h400, 32'h3, "owner");
    m.xfer(1, 8'hC3);
    rd_reg(12'h400, 32'h3, "owner");
    m.cs_high();
    rd_reg(12'h400, 32'h1, "owner");
    rd_reg(12'h128, 32'h1, "granted ev");
    // shortcut hands the buffers back without software
    wr_reg(12'h200, 32'h1);
    wr_reg(12'h028, 32'h1);
    rd_reg(12'h400, 32'h0, "owner");
    m.cs_low();
    rd_reg(12'h400, 32'h2, "owner");
    m.xfer(1, 8'h3C);
    m.cs_high();
    rd_reg(12'h400, 32'h1, "owner");
    rd_reg(12'h104, 32'h1, "done ev");
    wr_reg(12'h500, 32'h0);
    rd_reg(12'h500, 32'h0, "enable");
    wr_reg(12'h028, 32'h1);
    m.cs_low();
    rd_reg(12'h400, 32'h0, "owner");
    m.cs_high();
    // any code but 2 leaves the block off
    wr_reg(12'h500, 32'h1);
    rd_reg(12'h500, 32'h1, "enable");
    m.cs_low();
    rd_reg(12'h400, 32'h0, "owner");
    m.cs_high();
    rd_reg(12'h440, 32'h0, "errors");
    // cpu takes a free semaphore directly
    wr_reg(12'h128, 32'h1);
    rd_reg(12'h128, 32'h0, "granted ev");
    wr_reg(12'h024, 32'h1);
    rd_reg(12'h400, 32'h1, "owner");
    rd_reg(12'h128, 32'h1, "granted ev");
    report_and_stop();
  end
endmodule
